// *** rtl/job_cfg_map.vh ***
// register map and field layout of the decoder job configuration words
// assumes byte addressing on a 32-bit register port
`ifndef JOB_CFG_MAP_VH
`define JOB_CFG_MAP_VH
`define CFG0_OFFSET       20'h0_0000
`define CFG1_OFFSET       20'h0_0004
`define CFG0_WMASK        32'h7fff_7706
`define CFG1_WMASK        32'h007f_0000
`define CFG0_RESET        32'h0000_0000
`define CFG1_RESET        32'h0000_0000
`define FL_HI             30
`define FL_LO             16
`define FL_MAX            15'h5_0fa
`define SW_BIT            14
`define OUTPUT_PARAM_READ_FLAG_BIT          13
`define PERM_BIT          12
`define RATE_HI           10
`define RATE_LO           8
`define MODE_HI           2
`define MODE_LO           1
`define REL_HI            22
`define REL_LO            16
`define REL_MIN           7'h27
`define REL_MAX           7'h7f
`define MODE_SA           2'h0
`define MODE_FIRST        2'h1
`define MODE_MIDDLE       2'h2
`define MODE_LAST         2'h3
`define HTRANS_NONSEQ     2'h2
`endif

// *** rtl/cfg_word.v ***
// one configuration word with a per-bit writable mask
// assumes write enable and data come from the bus slave on the same clock
module cfg_word #(
    parameter [31:0] WMASK = 32'h0000_0000,
    parameter [31:0] RESET = 32'h0000_0000
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        wr_en,
    input  wire [31:0] wr_data,
    output wire [31:0] word_q
);
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1)
        begin : g_bit
            if (WMASK[i])
            begin : g_rw
                reg bit_q;
                always @(posedge hclk or negedge hresetn)
                begin
                    if (!hresetn)
                        bit_q <= RESET[i];
                    else if (wr_en)
                        bit_q <= wr_data[i];
                end
                assign word_q[i] = bit_q;
            end
            else
            begin : g_res
                // reserved: tied low, so writes have nowhere to land
                assign word_q[i] = 1'b0;
            end
        end
    endgenerate
endmodule // cfg_word

// *** rtl/job_cfg_regs.v ***
// decoder job configuration words 0 and 1 behind an AHB-Lite slave
// assumes a single master, whole-word transfers, one clock domain
`include "job_cfg_map.vh"

// How it works
// - reserved bits of both words read zero and ignore writes.
// - bits 30..16 of word 0 hold the frame length, at most 20730.
// - bit 14 of word 0 picks window count: 0 for size <=128, 1 above.
// - bit 13 set raises a read event for output parameters; clear, none.
// - bit 12 in standalone mode says a permutation table is delivered.
// - bits 10..8 give rate 1/value, with zero meaning rate 3/4.
// - bits 2..1 decode as standalone, first, middle and last subframe.
// - the subframe type chooses how the prolog sections start.
// - bits 22..16 of word 1 hold reliability length plus one, 39..127.
// - word 0 sits at offset 0x00000 and word 1 at 0x00004.
module job_cfg_regs (
    hclk,
    hresetn,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hready,
    hwdata,
    hrdata,
    hreadyout,
    hresp,
    job_start,
    frame_length,
    slide_window_count_select,
    output_read_event,
    permutation_table_load_flag,
    rate_divisor,
    rate_three_quarter,
    standalone_mode,
    shared_processing_mode,
    prolog_first,
    prolog_middle,
    prolog_last,
    frame_length_ok,
    reliability_len_p1,
    reliability_ok
);
    input  wire        hclk;
    input  wire        hresetn;
    input  wire        hsel;
    input  wire [19:0] haddr;
    input  wire [1:0]  htrans;
    input  wire        hwrite;
    input  wire [2:0]  hsize;
    input  wire        hready;
    input  wire [31:0] hwdata;
    output reg  [31:0] hrdata;
    output reg         hreadyout;
    output reg         hresp;
    input  wire        job_start;
    output reg  [14:0] frame_length;
    output reg         slide_window_count_select;
    output reg         output_read_event;
    output reg         permutation_table_load_flag;
    output reg  [2:0]  rate_divisor;
    output reg         rate_three_quarter;
    output reg         standalone_mode;
    output reg         shared_processing_mode;
    output reg         prolog_first;
    output reg         prolog_middle;
    output reg         prolog_last;
    output reg         frame_length_ok;
    output reg  [6:0]  reliability_len_p1;
    output reg         reliability_ok;

    reg         wr_pend_q;
    reg  [19:0] wr_addr_q;
    reg         job_q;
    wire        addr_phase;
    wire        wr0;
    wire        wr1;
    wire [31:0] cfg0;
    wire [31:0] cfg1;
    wire [1:0]  mode;
    wire        fwd0;
    wire        fwd1;
    wire [14:0] frame_length_d;
    wire        frame_length_ok_d;
    wire        read_event_d;
    wire        perm_flag_d;
    wire        rate_three_quarter_d;
    wire        standalone_d;
    wire [2:0]  prolog_sel_d;
    wire [6:0]  reliability_d;
    wire        reliability_ok_d;

    assign addr_phase = hsel && hready && (htrans == `HTRANS_NONSEQ);

    // write data arrives one cycle after the address phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 20'h0_0000;
        end
        else
        begin
            wr_pend_q <= addr_phase && hwrite;
            if (addr_phase)
                wr_addr_q <= haddr;
        end
    end

    assign wr0 = wr_pend_q && (wr_addr_q == `CFG0_OFFSET);
    assign wr1 = wr_pend_q && (wr_addr_q == `CFG1_OFFSET);

    cfg_word #(
        .WMASK (`CFG0_WMASK),
        .RESET (`CFG0_RESET)
    ) u_cfg0 (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (wr0),
        .wr_data (hwdata),
        .word_q  (cfg0)
    );

    cfg_word #(
        .WMASK (`CFG1_WMASK),
        .RESET (`CFG1_RESET)
    ) u_cfg1 (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (wr1),
        .wr_data (hwdata),
        .word_q  (cfg1)
    );

    assign mode = cfg0[`MODE_HI:`MODE_LO];

    // next values of the decoded fields, taken from the stored words
    assign frame_length_d    = cfg0[`FL_HI:`FL_LO];
    assign frame_length_ok_d = (frame_length_d <= `FL_MAX);
    // one pulse as a job ends; not gated by mode, since keeping the
    // flag clear in shared processing is left to software
    assign read_event_d = job_q && !job_start && cfg0[`OUTPUT_PARAM_READ_FLAG_BIT];
    // the table flag means nothing outside standalone, so it is masked
    assign perm_flag_d = cfg0[`PERM_BIT] && (mode == `MODE_SA);
    assign rate_three_quarter_d = (cfg0[`RATE_HI:`RATE_LO] == 3'h0);
    assign standalone_d = (mode == `MODE_SA);
    // one line each for first, middle and last subframes, picking how the prologs start
    assign prolog_sel_d = {(mode == `MODE_LAST),
                           (mode == `MODE_MIDDLE),
                           (mode == `MODE_FIRST)};
    assign reliability_d    = cfg1[`REL_HI:`REL_LO];
    // upper bound kept so a wider field would still be checked
    assign reliability_ok_d = (reliability_d >= `REL_MIN)
                              && (reliability_d <= `REL_MAX);

    // read data registered at the address phase; a write still in its
    // data phase is forwarded, else a read right behind it would return
    // the word as it was before that write
    assign fwd0 = wr0 && (haddr == `CFG0_OFFSET);
    assign fwd1 = wr1 && (haddr == `CFG1_OFFSET);

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (addr_phase && !hwrite)
        begin
            if (fwd0)
                hrdata <= hwdata & `CFG0_WMASK;
            else if (fwd1)
                hrdata <= hwdata & `CFG1_WMASK;
            else if (haddr == `CFG0_OFFSET)
                hrdata <= cfg0;
            else if (haddr == `CFG1_OFFSET)
                hrdata <= cfg1;
            else
                hrdata <= 32'h0000_0000;
        end
    end

    // no wait states and no error response: every access completes;
    // kept as flops so every bus output leaves a register
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // job tracking for the read event
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            job_q             <= 1'b0;
            output_read_event <= 1'b0;
        end
        else
        begin
            job_q             <= job_start;
            output_read_event <= read_event_d;
        end
    end

    // frame length; out-of-range values are stored and only flagged
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            frame_length    <= 15'h0000;
            frame_length_ok <= 1'b0;
        end
        else
        begin
            frame_length    <= frame_length_d;
            frame_length_ok <= frame_length_ok_d;
        end
    end

    // window count and code rate
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            slide_window_count_select <= 1'b0;
            rate_divisor              <= 3'h0;
            rate_three_quarter        <= 1'b0;
        end
        else
        begin
            slide_window_count_select <= cfg0[`SW_BIT];
            rate_divisor              <= cfg0[`RATE_HI:`RATE_LO];
            rate_three_quarter        <= rate_three_quarter_d;
        end
    end

    // permutation table flag
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            permutation_table_load_flag <= 1'b0;
        end
        else
        begin
            permutation_table_load_flag <= perm_flag_d;
        end
    end

    // processing mode; standalone is the reset mode
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            standalone_mode        <= 1'b1;
            shared_processing_mode <= 1'b0;
        end
        else
        begin
            standalone_mode        <= standalone_d;
            shared_processing_mode <= !standalone_d;
        end
    end

    // subframe type for the prolog start-up
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prolog_first  <= 1'b0;
            prolog_middle <= 1'b0;
            prolog_last   <= 1'b0;
        end
        else
        begin
            prolog_first  <= prolog_sel_d[0];
            prolog_middle <= prolog_sel_d[1];
            prolog_last   <= prolog_sel_d[2];
        end
    end

    // reliability length plus one and its range flag
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            reliability_len_p1 <= 7'h00;
            reliability_ok     <= 1'b0;
        end
        else
        begin
            reliability_len_p1 <= reliability_d;
            reliability_ok     <= reliability_ok_d;
        end
    end
endmodule // job_cfg_regs

// *** bench/job_cfg_regs_properties.sv ***
// checker: port-level properties of the job configuration words
// assumes hready is looped back from hreadyout by the bench
module job_cfg_regs_chk (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire        hready,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hrdata,
    input wire        job_start,
    input wire [14:0] frame_length,
    input wire        output_read_event,
    input wire        permutation_table_load_flag,
    input wire [2:0]  rate_divisor,
    input wire        rate_three_quarter,
    input wire        standalone_mode,
    input wire        shared_processing_mode,
    input wire        prolog_first,
    input wire        prolog_middle,
    input wire        prolog_last,
    input wire        frame_length_ok,
    input wire [6:0]  reliability_len_p1,
    input wire        reliability_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // reserved bits common to both words read zero, at unmapped addresses too
    a_resv_read_zero:
        assert property (hsel && hready && htrans == 2'h2 && !hwrite |=>
            (hrdata & 32'h8000_88f9) == 32'h0000_0000) else $error("resv set");
    a_mode_excl:
        assert property (standalone_mode ^ shared_processing_mode)
        else $error("mode flags clash");
    a_prolog_type:
        assert property ($onehot0({prolog_first, prolog_middle, prolog_last})
            && ((prolog_first | prolog_middle | prolog_last)
            == shared_processing_mode)) else $error("prolog type bad");
    a_perm_sa_only:
        assert property (permutation_table_load_flag |-> standalone_mode)
        else $error("perm flag outside standalone");
    // decoded flags lag reset release by one edge
    a_rate_zero:
        assert property ($past(hresetn) |->
            rate_three_quarter == (rate_divisor == 3'h0)) else $error("rate");
    a_fl_range:
        assert property ($past(hresetn) |->
            frame_length_ok == (frame_length <= 15'h5_0fa)) else $error("fl");
    a_rel_range:
        assert property (reliability_ok == (reliability_len_p1 >= 7'h27))
        else $error("reliability range");
    a_event_pulse:
        assert property (output_read_event |-> !$past(job_start) ##1
            !output_read_event) else $error("read event shape");
endmodule // job_cfg_regs_chk

bind job_cfg_regs job_cfg_regs_chk i_chk (.hclk, .hresetn, .hsel, .hready,
    .htrans, .hwrite, .hrdata, .job_start, .frame_length, .output_read_event,
    .permutation_table_load_flag, .rate_divisor, .rate_three_quarter,
    .standalone_mode, .shared_processing_mode, .prolog_first, .prolog_middle,
    .prolog_last, .frame_length_ok, .reliability_len_p1, .reliability_ok);

// *** bench/job_cfg_regs_test.sv ***
// bench: bus writes and reads of both words, decoded outputs, read event
// assumes zero-wait slave; hready is hreadyout, hsize fixed to a word
module job_cfg_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, job_start = 0;
    logic [19:0] haddr = '0;
    logic [1:0]  htrans = '0;
    logic [31:0] hwdata = '0, hrdata, rd;
    logic [14:0] frame_length;
    logic [6:0]  reliability_len_p1;
    logic [2:0]  rate_divisor;
    logic        hready, hresp, slide_window_count_select, output_read_event;
    logic        permutation_table_load_flag, rate_three_quarter;
    logic        standalone_mode, shared_processing_mode, prolog_first;
    logic        prolog_middle, prolog_last, frame_length_ok, reliability_ok;
    int          n_mismatch = 0, total_checks = 0, n;
    always #4 hclk = ~hclk;
    job_cfg_regs i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hready, .hwdata, .hrdata, .hreadyout(hready), .hresp,
        .job_start, .frame_length, .slide_window_count_select,
        .output_read_event, .permutation_table_load_flag, .rate_divisor,
        .rate_three_quarter, .standalone_mode, .shared_processing_mode,
        .prolog_first, .prolog_middle, .prolog_last, .frame_length_ok,
        .reliability_len_p1, .reliability_ok);
    task automatic summarize;
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [19:0] a,
                        input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        // decoded outputs trail the stored word by one edge
        @(posedge hclk);
        #1;
    endtask
    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(0, 20'h0_0000, '0); check("cfg0_rst", rd, '0);
        xfer(1, 20'h0_0000, '1); xfer(0, 20'h0_0000, '0);
        check("cfg0_mask", rd, 32'h7fff_7706);
        xfer(1, 20'h0_0004, '1); xfer(0, 20'h0_0004, '0);
        check("cfg1_mask", rd, 32'h007f_0000);
        xfer(1, 20'h0_0008, '1); xfer(0, 20'h0_0008, '0);
        check("unmapped", rd, '0);
        check("hresp", hresp, '0);
        for (int i = 0; i < 8; i++)
        begin
            // first and middle subframes are whole multiples of 256
            n = (i % 4 == 0) ? 20730 : (i % 4 == 3) ? 20731 : 20480;
            xfer(1, 20'h0_0000, (n << 16) | ((i % 2) << 14)
                | 32'h0000_1000 | (i << 8) | ((i % 4) << 1));
            check("fl", frame_length, n);
            check("fl_ok", frame_length_ok, i % 4 != 3);
            check("sw", slide_window_count_select, i % 2);
            check("rate", {rate_three_quarter, rate_divisor},
                {i == 0, 3'(i)});
            check("mode", {standalone_mode, shared_processing_mode,
                prolog_first, prolog_middle, prolog_last}, {i % 4 == 0,
                i % 4 != 0, i % 4 == 1, i % 4 == 2, i % 4 == 3});
            check("perm", permutation_table_load_flag, i % 4 == 0);
        end
        for (int k = 0; k < 3; k++)
        begin
            n = (k == 0) ? 38 : (k == 1) ? 39 : 127;
            xfer(1, 20'h0_0004, n << 16);
            check("rel", {reliability_ok, reliability_len_p1},
                {n >= 39, 7'(n)});
        end
        for (int f = 1; f >= 0; f--)
        begin
            xfer(1, 20'h0_0000, f << 13);
            @(posedge hclk);
            job_start <= 1'b1;
            repeat (3) @(posedge hclk);
            job_start <= 1'b0;
            n = 0;
            repeat (6)
            begin
                @(posedge hclk);
                #1;
                n += output_read_event;
            end
            check("read_event", n, f);
        end
        summarize();
    end
    initial
    begin
        repeat (3000) @(posedge hclk);
        n_mismatch++;
        summarize();
    end
endmodule // job_cfg_regs_test
